// [rtl/eight_bit_general_purpose_port.sv]
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Direction bit zero makes pin high-impedance input
// R2 - Direction bit one drives output bit push-pull
// R3 - Weak pull-ups until direction register written
// R4 - Input register returns sampled pin levels
// R5 - Input register reads all ones after reset
// R6 - Output register sets levels on output pins
// R7 - Output register clears to zero on reset
// R8 - Pins seven and six take alternate functions
// R9 - Reset initialises all port registers
// R10 - Warm reset held low at least 1 ms; rst_i here is active high, and one clock edge with it high resets the port
// R11 - Reset already asserted at power-up accepted
// R12 - Direction register clears to zero on reset
module eight_bit_general_purpose_port (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [7:0] pin_i,
    output logic      [7:0] pin_o,
    output logic      [7:0] pin_oe_o,
    output logic      [7:0] pin_pullup_o,
    input  wire logic       alt_int_sel_i,
    input  wire logic       alt_wrh_sel_i,
    input  wire logic       int_n_i,
    output logic            wrh_n_o
);
    logic [7:0] port_direction_config_r;
    logic [7:0] port_pin_level_output_r;
    logic [7:0] pin_meta_r;
    logic [7:0] port_pin_level_input_r;
    logic [7:0] rdata_r;
    logic       dir_written_r;
    logic [7:0] rdata_nxt;

    wire        hit_dir = (reg_addr_i == gpio_port_pkg::ADDR_DIR);
    wire        hit_in  = (reg_addr_i == gpio_port_pkg::ADDR_IN);
    wire        hit_out = (reg_addr_i == gpio_port_pkg::ADDR_OUT);
    wire        wr_dir  = reg_wr_i && hit_dir;
    wire        wr_out  = reg_wr_i && hit_out;

    // Unmapped addresses read as zero
    assign rdata_nxt = hit_in  ? port_pin_level_input_r  :
                       hit_dir ? port_direction_config_r :
                       hit_out ? port_pin_level_output_r : gpio_port_pkg::RD_IDLE;

    // R9 register init
    // R11 level-sensitive, no edge needed
    // R12 direction clears
    // R7 output clears
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            port_direction_config_r <= gpio_port_pkg::DIR_RST;
            port_pin_level_output_r <= gpio_port_pkg::OUT_RST;
            dir_written_r           <= 1'b0;
        end else begin
            if (wr_dir) begin
                port_direction_config_r <= reg_wdata_i;
                dir_written_r           <= 1'b1;
            end
            // R6 output register write
            if (wr_out) begin
                port_pin_level_output_r <= reg_wdata_i;
            end
        end
    end

    // Pins are asynchronous, so two flops before any reader
    // R5 input reads ones
    // R4 pin sampling
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_meta_r             <= gpio_port_pkg::IN_RST;
            port_pin_level_input_r <= gpio_port_pkg::IN_RST;
        end else begin
            pin_meta_r             <= pin_i;
            port_pin_level_input_r <= pin_meta_r;
        end
    end

    // R4 registered read data
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_r <= gpio_port_pkg::RD_IDLE;
        end else if (reg_rd_i) begin
            rdata_r <= rdata_nxt;
        end
    end
    assign reg_rdata_o = rdata_r;

    // R1 input high-impedance
    // R2 push-pull output
    // R8 alternate pin functions
    always_comb begin
        pin_o    = port_pin_level_output_r;
        pin_oe_o = port_direction_config_r;
        if (alt_int_sel_i) begin
            pin_o[gpio_port_pkg::PIN_INT]    = int_n_i;
            pin_oe_o[gpio_port_pkg::PIN_INT] = 1'b1;
        end
        if (alt_wrh_sel_i) begin
            pin_o[gpio_port_pkg::PIN_WRH]    = 1'b0;
            pin_oe_o[gpio_port_pkg::PIN_WRH] = 1'b0;
        end
    end

    // R8 strobe taken from synchronised pin
    assign wrh_n_o = alt_wrh_sel_i ? port_pin_level_input_r[gpio_port_pkg::PIN_WRH] : 1'b1;

    // R3 pull-ups until configured
    assign pin_pullup_o = {8{~dir_written_r}};

    default clocking cb @(posedge sys_clk_i); endclocking

    a_dir_input_hiz: assert property (disable iff (rst_i) // R1
        !alt_int_sel_i && !alt_wrh_sel_i |-> ((~port_direction_config_r & pin_oe_o) == 8'h00))
        else $error("input pin is driven");
    a_dir_output_drv: assert property (disable iff (rst_i) // R2
        wr_dir && !alt_int_sel_i ##1 !alt_int_sel_i && !alt_wrh_sel_i
        |-> pin_oe_o == $past(reg_wdata_i))
        else $error("output enables do not follow direction write");
    a_pullup_hold: assert property (disable iff (rst_i) // R3
        wr_dir |=> (pin_pullup_o == 8'h00) [*3])
        else $error("pull-ups remain after configuration");
    a_pullup_reset: assert property ( // R3
        rst_i |=> pin_pullup_o == 8'hFF)
        else $error("pull-ups missing after reset");
    a_in_sample: assert property (disable iff (rst_i) // R4
        ##3 (reg_rd_i && hit_in) |=> reg_rdata_o == $past(pin_i, 3))
        else $error("input read does not show pin level");
    a_in_reset: assert property ( // R5
        rst_i |=> port_pin_level_input_r == 8'hFF)
        else $error("input register not all ones after reset");
    a_out_write: assert property (disable iff (rst_i) // R6
        wr_out && !wr_dir ##1 (port_direction_config_r == 8'hFF) && !alt_int_sel_i && !alt_wrh_sel_i
        |-> pin_o == $past(reg_wdata_i))
        else $error("output pins do not show written value");
    a_out_reset: assert property ( // R7
        rst_i |=> port_pin_level_output_r == 8'h00)
        else $error("output register not cleared by reset");
    a_alt_int: assert property (disable iff (rst_i) // R8
        alt_int_sel_i |-> pin_oe_o[6] && (pin_o[6] == int_n_i))
        else $error("interrupt pin not driven");
    a_alt_wrh: assert property (disable iff (rst_i) // R8
        alt_wrh_sel_i |-> !pin_oe_o[7] && (wrh_n_o == port_pin_level_input_r[7]))
        else $error("strobe pin not an input");
    a_dir_reset: assert property ( // R12
        rst_i |=> port_direction_config_r == 8'h00 && dir_written_r == 1'b0)
        else $error("direction register not cleared by reset");

    c_read_in:   cover property (disable iff (rst_i) reg_rd_i && hit_in);
    c_dir_write: cover property (disable iff (rst_i) wr_dir ##1 wr_out);
    c_alt_int:   cover property (disable iff (rst_i) alt_int_sel_i && !int_n_i);
    c_alt_wrh:   cover property (disable iff (rst_i) alt_wrh_sel_i && !wrh_n_o);
endmodule : eight_bit_general_purpose_port

// [rtl/gpio_port_pkg.sv]
package gpio_port_pkg;
    localparam int unsigned PORT_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_DIR = 8'hAF;
    localparam logic [7:0] ADDR_IN  = 8'hCF;
    localparam logic [7:0] ADDR_OUT = 8'hEF;

    // Values after reset
    localparam logic [7:0] DIR_RST  = 8'h00;
    localparam logic [7:0] IN_RST   = 8'hFF;
    localparam logic [7:0] OUT_RST  = 8'h00;
    localparam logic [7:0] RD_IDLE  = 8'h00;

    // Bit positions of the shared pins
    localparam int unsigned PIN_INT = 6;
    localparam int unsigned PIN_WRH = 7;
endpackage : gpio_port_pkg

// [tb/ext_pins.sv]
`timescale 1ns/1ns
module ext_pins (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] en_i,
    input  wire logic [7:0] val_i,
    output logic      [7:0] lvl_o
);
    logic [7:0] last_r = 8'h00;
    // drive, float, pull-up
    // A floating line shows the inverse of its last level, so no stale value passes
    assign lvl_o = (oe_i & pin_o_i) | (~oe_i & en_i & val_i) | (~oe_i & ~en_i & (pu_i | ~last_r));
    always_ff @(posedge clk_i) begin
        last_r <= lvl_o;
    end
endmodule : ext_pins

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    logic       sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic       alt_int_sel_i = 1'b0, alt_wrh_sel_i = 1'b0, int_n_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, en = 8'h00, val = 8'h00, dir, outv;
    wire  [7:0] reg_rdata_o, pin_i, pin_o, pin_oe_o, pin_pullup_o;
    wire        wrh_n_o;
    int         err_count = 0, n_compared = 0, cyc = 0;
    eight_bit_general_purpose_port dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .pin_i, .pin_o, .pin_oe_o, .pin_pullup_o, .alt_int_sel_i, .alt_wrh_sel_i, .int_n_i, .wrh_n_o);
    ext_pins ext (.clk_i(sys_clk_i), .pin_o_i(pin_o), .oe_i(pin_oe_o), .pu_i(pin_pullup_o), .en_i(en),
        .val_i(val), .lvl_o(pin_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    task wrap_up;
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : chk
    // One bus cycle; a read compares against d
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = w;
        reg_rd_i = !w;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        if (!w) chk(reg_rdata_o, d);
    endtask : acc
    function logic [7:0] lvl(input logic [7:0] d, input logic [7:0] o, input logic [7:0] v);
        return (d & o) | (~d & v);
    endfunction : lvl
    initial begin
        void'($urandom(86872));
        repeat (12) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk(pin_pullup_o, 8'hFF);
        chk(pin_oe_o, 8'h00);
        acc(1'b0, gpio_port_pkg::ADDR_IN, gpio_port_pkg::IN_RST);
        acc(1'b0, gpio_port_pkg::ADDR_OUT, gpio_port_pkg::OUT_RST);
        acc(1'b0, gpio_port_pkg::ADDR_DIR, gpio_port_pkg::DIR_RST);
        acc(1'b0, 8'h12, gpio_port_pkg::RD_IDLE);
        en = 8'hFF;
        for (int i = 0; i < 22; i++) begin
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            outv = 8'($urandom);
            val = 8'($urandom);
            acc(1'b1, gpio_port_pkg::ADDR_DIR, dir);
            acc(1'b1, gpio_port_pkg::ADDR_OUT, outv);
            acc(1'b1, gpio_port_pkg::ADDR_IN, ~outv);
            repeat (3) @(negedge sys_clk_i);
            chk(pin_oe_o, dir);
            chk(pin_o & dir, outv & dir);
            chk(pin_pullup_o, 8'h00);
            acc(1'b0, gpio_port_pkg::ADDR_IN, lvl(dir, outv, val));
            acc(1'b0, gpio_port_pkg::ADDR_OUT, outv);
        end
        for (int k = 0; k < 2; k++) begin
            @(negedge sys_clk_i);
            alt_int_sel_i = 1'b1;
            alt_wrh_sel_i = 1'b1;
            int_n_i = k[0];
            val = {k[0], 7'h00};
            repeat (4) @(negedge sys_clk_i);
            chk(pin_oe_o & 8'hC0, 8'h40);
            chk(pin_o & 8'h40, {1'b0, k[0], 6'h00});
            chk({7'h00, wrh_n_o}, {7'h00, k[0]});
        end
        alt_int_sel_i = 1'b0;
        alt_wrh_sel_i = 1'b0;
        @(negedge sys_clk_i);
        chk({7'h00, wrh_n_o}, 8'h01);
        rst_i = 1'b1;
        repeat (12) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk(pin_pullup_o, 8'hFF);
        acc(1'b0, gpio_port_pkg::ADDR_OUT, gpio_port_pkg::OUT_RST);
        wrap_up();
    end
endmodule : tb_top
